//--- dv/iatr_regs_sva.sv
// checker: bus wait, reserved bits and alarm compare relations of the threshold slice
module iatr_regs_sva
    import iatr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire iatr_avl_req_type avl_req_in,
    input wire logic [DATA_W-1:0] avl_readdata_out,
    input wire logic avl_waitrequest_out,
    input wire iatr_sample_type sample_in,
    input wire iatr_flags_type flags_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [11:0] up_reg;
    logic [11:0] lo_reg;
    logic [1:0] hy_reg;
    logic [11:0] smp;
    logic wr_done;
    assign smp = sample_in.data[15:4];
    assign wr_done = avl_req_in.write & ~avl_waitrequest_out;
    // shadow of the compare fields, taken when a write completes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_reg <= 12'hfff;
            lo_reg <= 12'h000;
            hy_reg <= 2'h0;
        end else if (wr_done && avl_req_in.address == UPPER_OFS) begin
            if (avl_req_in.byteenable[0]) up_reg[3:0] <= avl_req_in.writedata[7:4];
            if (avl_req_in.byteenable[1]) up_reg[11:4] <= avl_req_in.writedata[15:8];
            if (avl_req_in.byteenable[3]) hy_reg <= avl_req_in.writedata[31:30];
        end else if (wr_done && avl_req_in.address == LOWER_OFS) begin
            if (avl_req_in.byteenable[0]) lo_reg[3:0] <= avl_req_in.writedata[7:4];
            if (avl_req_in.byteenable[1]) lo_reg[11:4] <= avl_req_in.writedata[15:8];
        end
    end
    sequence s_rd_done(logic [ADDR_W-1:0] a);
        avl_req_in.read && !avl_waitrequest_out && avl_req_in.address == a;
    endsequence
    a_wait_one: assert property (
        (avl_req_in.read || avl_req_in.write) && avl_waitrequest_out |=> !avl_waitrequest_out)
        else $error("wait lasted more than one cycle");
    a_rsv_upper: assert property (
        s_rd_done(UPPER_OFS) |-> avl_readdata_out[23:16] == 8'h00)
        else $error("upper reserved bits not zero");
    a_rsv_lower: assert property (
        s_rd_done(LOWER_OFS) |-> avl_readdata_out[31:16] == 16'h0000)
        else $error("lower reserved bits not zero");
    a_hi_set: assert property (
        sample_in.valid && smp > up_reg |=> flags_out.active_hi)
        else $error("high alarm not raised");
    a_hi_clear: assert property (
        sample_in.valid && ({1'b0, smp} + hy_reg) < {1'b0, up_reg} |=> !flags_out.active_hi)
        else $error("high alarm not cleared");
    a_lo_set: assert property (
        sample_in.valid && smp < lo_reg |=> flags_out.active_lo)
        else $error("low alarm not raised");
    a_lo_clear: assert property (
        sample_in.valid && {1'b0, smp} > ({1'b0, lo_reg} + hy_reg) |=> !flags_out.active_lo)
        else $error("low alarm not cleared");
    a_active_hold: assert property (
        !sample_in.valid |=> $stable({flags_out.active_hi, flags_out.active_lo}))
        else $error("alarm moved without a sample");
    a_trip_follow: assert property (
        ({flags_out.active_hi, flags_out.active_lo}
        & ~{flags_out.tripped_hi, flags_out.tripped_lo}) == 2'b00)
        else $error("tripped flag missing");
    a_summary_or: assert property (
        flags_out.summary == (flags_out.tripped_hi | flags_out.tripped_lo))
        else $error("summary not the or of tripped");
endmodule // iatr_regs_sva

bind iatr_regs iatr_regs_sva u_iatr_regs_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .avl_req_in(avl_req_in), .avl_readdata_out(avl_readdata_out),
    .avl_waitrequest_out(avl_waitrequest_out), .sample_in(sample_in),
    .flags_out(flags_out), .irq_out(irq_out));

//--- dv/tb.sv
// testbench: register access, reserved bits, alarm thresholds, status and interrupt
module tb
    import iatr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    iatr_avl_req_type req = '0;
    iatr_sample_type smp_in = '0;
    logic [31:0] rdata;
    logic wreq;
    iatr_flags_type flags;
    logic irq;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] exp_q[$];
    logic [31:0] d;
    // host fill for hysteresis byte bits 5-0; plain default
    localparam logic [5:0] HYST_FILL = 6'h00;
    always #10 sys_clk_in = ~sys_clk_in;
    iatr_regs u_iatr_regs (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .avl_req_in(req),
        .avl_readdata_out(rdata), .avl_waitrequest_out(wreq), .sample_in(smp_in),
        .flags_out(flags), .irq_out(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
        input logic [3:0] be, input logic [31:0] e);
        if (!wr) exp_q.push_back(e);
        req <= '{read: !wr, write: wr, address: a, writedata: wd, byteenable: be};
        do begin
            @(posedge sys_clk_in);
        end while (wreq !== 1'b0);
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic samp(input logic [15:0] v);
        smp_in <= {1'b1, v};
        @(posedge sys_clk_in);
        smp_in <= {1'b0, 16'($urandom)};
        @(posedge sys_clk_in);
    endtask
    task automatic irqc(input logic e);
        @(negedge sys_clk_in);
        check({31'h0, irq}, {31'h0, e});
        @(posedge sys_clk_in);
    endtask
    // read data are taken at the rising edge that completes the transfer
    always @(posedge sys_clk_in) begin
        if (req.read && wreq === 1'b0) check(rdata, exp_q.pop_front());
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        d = $urandom(76);
        repeat (10) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        bus(0, UPPER_OFS, 0, 0, 32'h0000ffff);
        bus(0, LOWER_OFS, 0, 0, 32'h00000000);
        bus(0, 6'h3c, 0, 0, UNMAPPED_READ);
        bus(0, STATUS_OFS, 0, 0, 32'h00000000);
        $display("test reset values done");
        bus(1, UPPER_OFS, {2'h3, HYST_FILL, 24'hfffff0}, 4'hf, 0);
        bus(0, UPPER_OFS, 0, 0, {2'h3, HYST_FILL, 24'h00fff0});
        bus(1, UPPER_OFS, 32'h000000a0, 4'h1, 0);
        bus(0, UPPER_OFS, 0, 0, {2'h3, HYST_FILL, 24'h00ffa0});
        for (int i = 0; i < 4; i++) begin
            d = $urandom() & 32'hffff_fff0;
            bus(1, LOWER_OFS, d, 4'hf, 0);
            bus(0, LOWER_OFS, 0, 0, {16'h0000, d[15:0]});
        end
        bus(1, LOWER_OFS, 32'h00003c00, 4'h2, 0);
        bus(0, LOWER_OFS, 0, 0, {16'h0000, 8'h3c, d[7:0]});
        $display("test register layout done");
        bus(1, UPPER_OFS, {2'h2, HYST_FILL, 24'h008000}, 4'hf, 0);
        bus(1, LOWER_OFS, 32'h00002000, 4'hf, 0);
        samp(16'h8000);
        samp(16'h2000);
        bus(0, STATUS_OFS, 0, 0, 32'h00000000);
        samp(16'h801f);
        check({27'h0, flags}, 32'h00000015);
        bus(0, STATUS_OFS, 0, 0, 32'h00000411);
        samp(16'h7fe0);
        bus(0, STATUS_OFS, 0, 0, 32'h00000411);
        samp(16'h7fd0);
        bus(0, STATUS_OFS, 0, 0, 32'h00000011);
        bus(0, STATUS_OFS, 0, 0, 32'h00000000);
        samp(16'h1ff0);
        check({27'h0, flags}, 32'h0000000b);
        samp(16'h2020);
        bus(0, STATUS_OFS, 0, 0, 32'h00000821);
        samp(16'h2030);
        bus(0, STATUS_OFS, 0, 0, 32'h00000021);
        bus(0, STATUS_OFS, 0, 0, 32'h00000000);
        $display("test alarm thresholds done");
        bus(0, IRQ_STAT_OFS, 0, 0, 32'h00000003);
        irqc(1'b0);
        bus(1, IRQ_MASK_OFS, 32'h00000001, 4'hf, 0);
        irqc(1'b1);
        bus(1, IRQ_STAT_OFS, 32'h00000001, 4'hf, 0);
        irqc(1'b0);
        bus(0, IRQ_STAT_OFS, 0, 0, 32'h00000002);
        bus(1, IRQ_MASK_OFS, 32'h00000003, 4'hf, 0);
        irqc(1'b1);
        bus(1, IRQ_STAT_OFS, 32'h00000002, 4'hf, 0);
        irqc(1'b0);
        bus(0, IRQ_MASK_OFS, 0, 0, 32'h00000003);
        $display("test interrupt done");
        complete_run();
    end
endmodule // tb

//--- rtl/iatr_pkg.sv
// package: register map, field layout and bus carriers of the input alarm threshold slice
package iatr_pkg;

    // ------------------------------------------------------------
    // bus and data widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int CMP_W = 12;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h20;
    localparam logic [ADDR_W-1:0] UPPER_OFS = 6'h24;
    localparam logic [ADDR_W-1:0] LOWER_OFS = 6'h28;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 6'h30;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 6'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HYST_MSB = 31;
    localparam int HYST_LSB = 24;
    localparam int HYST_AMT_MSB = 31;
    localparam int HYST_AMT_LSB = 30;
    localparam int LIMIT_MSB = 15;
    localparam int LIMIT_CMP_LSB = 4;
    localparam int ST_ACTIVE_LO_BIT = 11;
    localparam int ST_ACTIVE_HI_BIT = 10;
    localparam int ST_TRIP_LO_BIT = 5;
    localparam int ST_TRIP_HI_BIT = 4;
    localparam int ST_SUMMARY_BIT = 0;
    localparam int IRQ_HI_BIT = 0;
    localparam int IRQ_LO_BIT = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HYST_RST = 8'h00;
    localparam logic [15:0] UPPER_LIMIT_RST = 16'hffff;
    localparam logic [15:0] LOWER_LIMIT_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } iatr_avl_req_type;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } iatr_sample_type;

    typedef struct packed {
        logic active_hi;
        logic active_lo;
        logic tripped_hi;
        logic tripped_lo;
        logic summary;
    } iatr_flags_type;

endpackage

//--- rtl/iatr_regs.sv
// input alarm threshold registers with hysteresis comparator, alarm status and interrupt
module iatr_regs
    import iatr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire iatr_avl_req_type avl_req_in,
    output logic [DATA_W-1:0] avl_readdata_out,
    output logic avl_waitrequest_out,
    input wire iatr_sample_type sample_in,
    output iatr_flags_type flags_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic [7:0] hyst;
        logic [15:0] upper;
        logic [15:0] lower;
        logic active_hi;
        logic active_lo;
        logic tripped_hi;
        logic tripped_lo;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic summary;
        logic irq;
    } iatr_state_type;

    localparam iatr_state_type STATE_RST = '{
        ack: 1'b0,
        rdata: UNMAPPED_READ,
        hyst: HYST_RST,
        upper: UPPER_LIMIT_RST,
        lower: LOWER_LIMIT_RST,
        active_hi: 1'b0,
        active_lo: 1'b0,
        tripped_hi: 1'b0,
        tripped_lo: 1'b0,
        irq_stat: '0,
        irq_mask: IRQ_MASK_RST,
        summary: 1'b0,
        irq: 1'b0
    };

    iatr_state_type state_reg;
    iatr_state_type state_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge a 32-bit write into a stored word, one byte lane at a time
    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [3:0] lanes
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // the comparable part of a 16-bit limit or sample
    function automatic logic [CMP_W:0] cmp_part(input logic [15:0] value);
        return {1'b0, value[LIMIT_MSB:LIMIT_CMP_LSB]};
    endfunction

    // word index of a byte address; the two low bits only pick a byte lane
    function automatic logic [ADDR_W-1:2] word_of(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2];
    endfunction

    // ------------------------------------------------------------
    // word packing
    // ------------------------------------------------------------
    // hysteresis byte on top, 16-bit limit below; bits 23-16 always read zero
    function automatic logic [DATA_W-1:0] limit_word(
        input logic [7:0] hyst_byte,
        input logic [15:0] limit
    );
        logic [DATA_W-1:0] res;
        res = '0;
        res[HYST_MSB:HYST_LSB] = hyst_byte;
        res[LIMIT_MSB:0] = limit;
        return res;
    endfunction

    // status word: active and tripped flags with the summary bit
    function automatic logic [DATA_W-1:0] status_word(input iatr_state_type st);
        logic [DATA_W-1:0] res;
        res = '0;
        res[ST_ACTIVE_LO_BIT] = st.active_lo;
        res[ST_ACTIVE_HI_BIT] = st.active_hi;
        res[ST_TRIP_LO_BIT] = st.tripped_lo;
        res[ST_TRIP_HI_BIT] = st.tripped_hi;
        res[ST_SUMMARY_BIT] = st.summary;
        return res;
    endfunction

    // interrupt register bits, zero-extended to a bus word
    function automatic logic [DATA_W-1:0] irq_word(input logic [IRQ_W-1:0] bits);
        return {{(DATA_W-IRQ_W){1'b0}}, bits};
    endfunction

    // ------------------------------------------------------------
    // alarm helpers
    // ------------------------------------------------------------
    // one hysteresis alarm: set past the limit, cleared only once back inside by the margin
    function automatic logic alarm_next(
        input logic active,
        input logic valid,
        input logic past_limit,
        input logic back_inside
    );
        logic res;
        res = active;
        if (valid) begin
            if (past_limit) begin
                res = 1'b1;
            end else if (back_inside) begin
                res = 1'b0;
            end
        end
        return res;
    endfunction

    // sticky bits: a set in the same cycle as a clear wins
    function automatic logic [1:0] sticky_next(
        input logic [1:0] old_bits,
        input logic [1:0] clear_bits,
        input logic [1:0] set_bits
    );
        return (old_bits & ~clear_bits) | set_bits;
    endfunction

    // ------------------------------------------------------------
    // read view of the registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] upper_view;
    logic [DATA_W-1:0] lower_view;
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] read_mux;

    always_comb begin
        upper_view = limit_word(state_reg.hyst, state_reg.upper);
        lower_view = limit_word(8'h00, state_reg.lower); // upper half reads zero
        status_view = status_word(state_reg);
    end

    always_comb begin
        read_mux = UNMAPPED_READ;
        unique case (word_of(avl_req_in.address))
            STATUS_OFS[ADDR_W-1:2]: read_mux = status_view;
            UPPER_OFS[ADDR_W-1:2]: read_mux = upper_view;
            LOWER_OFS[ADDR_W-1:2]: read_mux = lower_view;
            IRQ_STAT_OFS[ADDR_W-1:2]: read_mux = irq_word(state_reg.irq_stat);
            IRQ_MASK_OFS[ADDR_W-1:2]: read_mux = irq_word(state_reg.irq_mask);
            default: read_mux = UNMAPPED_READ;
        endcase
    end

    // ------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------
    logic [CMP_W:0] sample_cmp;
    logic [CMP_W:0] upper_cmp;
    logic [CMP_W:0] lower_cmp;
    logic [CMP_W:0] hyst_amt;
    logic above_upper;
    logic below_upper_hyst;
    logic below_lower;
    logic above_lower_hyst;

    always_comb begin
        sample_cmp = cmp_part(sample_in.data);
        upper_cmp = cmp_part(state_reg.upper);
        lower_cmp = cmp_part(state_reg.lower);
        hyst_amt = {{(CMP_W-1){1'b0}}, state_reg.hyst[7:6]};
        above_upper = sample_cmp > upper_cmp;
        below_upper_hyst = (sample_cmp + hyst_amt) < upper_cmp;
        below_lower = sample_cmp < lower_cmp;
        above_lower_hyst = sample_cmp > (lower_cmp + hyst_amt);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic req;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [ADDR_W-1:2] word_addr;
    logic [DATA_W-1:0] upper_merged;
    logic [DATA_W-1:0] lower_merged;
    logic [IRQ_W-1:0] rise;
    logic [IRQ_W-1:0] w1c;
    logic [1:0] trip_clear;

    always_comb begin
        state_next = state_reg;
        req = avl_req_in.read | avl_req_in.write;
        hit = req & state_reg.ack;
        wr_hit = hit & avl_req_in.write;
        rd_hit = hit & avl_req_in.read;
        word_addr = word_of(avl_req_in.address);
        upper_merged = merge_bytes(upper_view, avl_req_in.writedata, avl_req_in.byteenable);
        lower_merged = merge_bytes(lower_view, avl_req_in.writedata, avl_req_in.byteenable);
        rise = '0;
        w1c = '0;
        trip_clear = '0;

        // bus handshake: one wait cycle, data captured in it
        state_next.ack = req & ~state_reg.ack;
        if (req & ~state_reg.ack) begin
            state_next.rdata = avl_req_in.read ? read_mux : UNMAPPED_READ;
        end

        // register writes
        if (wr_hit) begin
            unique case (word_addr)
                UPPER_OFS[ADDR_W-1:2]: begin
                    state_next.hyst = upper_merged[HYST_MSB:HYST_LSB];
                    state_next.upper = upper_merged[LIMIT_MSB:0];
                end
                LOWER_OFS[ADDR_W-1:2]: begin
                    state_next.lower = lower_merged[LIMIT_MSB:0];
                end
                IRQ_STAT_OFS[ADDR_W-1:2]: begin
                    w1c = avl_req_in.writedata[IRQ_W-1:0];
                end
                IRQ_MASK_OFS[ADDR_W-1:2]: begin
                    state_next.irq_mask = avl_req_in.writedata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // reading status clears only the tripped flags that were reported
        if (rd_hit && word_addr == STATUS_OFS[ADDR_W-1:2]) begin
            trip_clear[0] = state_reg.rdata[ST_TRIP_HI_BIT];
            trip_clear[1] = state_reg.rdata[ST_TRIP_LO_BIT];
        end

        // hysteresis comparator on each valid sample
        state_next.active_hi = alarm_next(state_reg.active_hi, sample_in.valid, above_upper,
            below_upper_hyst);
        state_next.active_lo = alarm_next(state_reg.active_lo, sample_in.valid, below_lower,
            above_lower_hyst);
        rise[IRQ_HI_BIT] = state_next.active_hi & ~state_reg.active_hi;
        rise[IRQ_LO_BIT] = state_next.active_lo & ~state_reg.active_lo;

        // tripped flags: an alarm that is still active wins over a read clear
        {state_next.tripped_lo, state_next.tripped_hi} = sticky_next(
            {state_reg.tripped_lo, state_reg.tripped_hi}, trip_clear,
            {state_next.active_lo, state_next.active_hi});
        state_next.summary = state_next.tripped_hi | state_next.tripped_lo;

        // sticky interrupt status: set wins over write-one-to-clear
        state_next.irq_stat = sticky_next(state_reg.irq_stat, w1c, rise);
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avl_waitrequest_out = (avl_req_in.read | avl_req_in.write) & ~state_reg.ack;
    assign avl_readdata_out = state_reg.rdata;
    assign flags_out = '{
        active_hi: state_reg.active_hi,
        active_lo: state_reg.active_lo,
        tripped_hi: state_reg.tripped_hi,
        tripped_lo: state_reg.tripped_lo,
        summary: state_reg.summary
    };
    assign irq_out = state_reg.irq;

endmodule // iatr_regs
